// ===== core/adcss_buf.sv
`default_nettype none
module adcss_buf #(
    parameter int W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    adcss_stream_if.snk in_s,
    adcss_stream_if.src out_s
);
    typedef struct packed {
        logic [1:0][W-1:0] ent;
        logic [1:0] cnt;
    } adcss_buf_t;

    adcss_buf_t r;
    adcss_buf_t n;
    logic push;
    logic pop;
    logic [1:0] widx;

    assign in_s.ready = (r.cnt != 2'd2);
    assign out_s.valid = (r.cnt != 2'd0);
    assign out_s.data = r.ent[0];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        n = r;
        widx = r.cnt - {1'b0, pop};
        if (pop) begin
            n.ent[0] = r.ent[1];
        end
        if (push) begin
            n.ent[widx[0]] = in_s.data;
        end
        n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    buf_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (r.cnt == 2'd2 && !pop) |=> (r.cnt == 2'd2 && !in_s.ready))
        else $error("two-entry buffer lost or overfilled a word");
endmodule
`default_nettype wire

// ===== core/adcss_pkg.sv
`default_nettype none
package adcss_pkg;
    localparam int NUM_SEQ = 4;
    localparam int MAX_STEPS = 8;
    localparam int RES_W = 10;
    localparam int WORD_W = 32;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int NIB_W = 4;
    localparam int RANK_W = 2;
    localparam int EVT_W = 8;
    localparam int AVG_W = 3;
    localparam int AVG_MAX_LOG = 6;
    localparam int ACC_W = RES_W + AVG_MAX_LOG;
    localparam int QSTATE_W = 2 * NIB_W + 2;
    localparam int QST_EMPTY_BIT = 2 * NIB_W;
    localparam int QST_FULL_BIT = 2 * NIB_W + 1;
    localparam logic [QSTATE_W-1:0] QSTATE_RESET = 10'h100;
    // step control nibble bit positions
    localparam int CTL_DIFF_BIT = 0;
    localparam int CTL_LAST_BIT = 1;
    localparam int CTL_IRQ_BIT = 2;
    localparam int CTL_TEMP_BIT = 3;
    // trigger source select codes; codes 1..8 pick an event input
    localparam logic [NIB_W-1:0] TRIG_SOFT = 4'h0;
    localparam logic [NIB_W-1:0] TRIG_ALWAYS = 4'hf;
    localparam logic [NIB_W-1:0] TRIG_EVT_FIRST = 4'h1;
    localparam logic [NUM_SEQ*NIB_W-1:0] RANK_RESET = 16'h3210;
    localparam logic [AVG_W-1:0] AVG_RESET = 3'h0;
    // converter clock enable: 50 MHz system clock, 16.667 MHz target
    localparam int CLK_KHZ = 50000;
    localparam int CNV_TARGET_KHZ = 16667;
    localparam int CNV_DIV = (CLK_KHZ + CNV_TARGET_KHZ / 2) / CNV_TARGET_KHZ;
    localparam int CNV_CNT_W = 2;
    localparam logic [CNV_CNT_W-1:0] CNV_LAST = CNV_CNT_W'(CNV_DIV - 1);
    localparam logic [NUM_SEQ-1:0][NIB_W-1:0] SEQ_DEPTH_DEF = {4'h1, 4'h4, 4'h4, 4'h8};
    localparam int BUF_W = 2 + RES_W;
endpackage
`default_nettype wire

// ===== core/adcss_stream_if.sv
`default_nettype none
interface adcss_stream_if #(parameter int W = 12);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== core/adcss_top.sv
`default_nettype none
// Contract
// - each result queue word is 32 bits, conversion result in the low 10 bits.
// - queue depths and step counts: sequencer 0 eight, 1 and 2 four, 3 one.
// - a step is one input-select nibble plus one control nibble of four flags.
// - a sequencer runs only while its run bit is set; configuration is always writable.
// - the same input may appear in several steps and is converted each time.
// - a step carrying the interrupt flag raises the raw interrupt on completion.
// - the sequence ends after the step carrying the last-step flag.
// - each queue is circular; a read returns and removes the oldest word.
// - head, tail, full and empty of each queue are readable.
// - overrun on push and starve on read are held per sequencer.
// - conversions are paced by a 16.667 MHz enable from the system clock.
// - the interrupt line rises only for sequencers whose allow bit is set.
// - gated status is raw status and the allow bits.
// - writing one to a gated status bit clears that interrupt; zero does nothing.
// - simultaneous triggers are served by rank, 0 highest, 3 lowest.
// - each sequencer picks its trigger: software kick, always, or an event.
// - the averager folds up to 64 conversions into one queue word.
// - averaging is off after reset and applies alike to every step.
// - a differential step selects pair k, converting inputs 2k and 2k+1.
// - result codes pass unchanged, differential midscale at 0x1ff.
// - a loopback test mode produces results without the analog core.
// - after reset the ranks are 0,1,2,3 for sequencers 0 to 3.
module adcss_top
    import adcss_pkg::*;
#(
    parameter logic [NUM_SEQ-1:0][NIB_W-1:0] SEQ_DEPTH = SEQ_DEPTH_DEF
) (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [NUM_SEQ-1:0] SEQUENCER_ACTIVATION_I,
    input wire logic [NUM_SEQ-1:0][MAX_STEPS-1:0][NIB_W-1:0] STEP_INPUT_SELECT_I,
    input wire logic [NUM_SEQ-1:0][MAX_STEPS-1:0][NIB_W-1:0] STEP_CONTROL_NIBBLES_I,
    input wire logic [NUM_SEQ-1:0][NIB_W-1:0] TRIGGER_SOURCE_SELECT_I,
    input wire logic [EVT_W-1:0] TRIGGER_EVENT_I,
    input wire logic [NUM_SEQ-1:0] SOFTWARE_KICK_BITS_I,
    input wire logic [NUM_SEQ-1:0][NIB_W-1:0] SEQUENCER_RANK_I,
    input wire logic SEQUENCER_RANK_WR_I,
    input wire logic [AVG_W-1:0] AVERAGING_SETTING_I,
    input wire logic AVERAGING_SETTING_WR_I,
    input wire logic LOOPBACK_TEST_SETTING_I,
    input wire logic [NUM_SEQ-1:0] IRQ_ALLOW_REG_I,
    input wire logic [NUM_SEQ-1:0] GATED_IRQ_STATE_CLEAR_I,
    input wire logic [NUM_SEQ-1:0] QUEUE_OVERRUN_CLEAR_I,
    input wire logic [NUM_SEQ-1:0] QUEUE_STARVE_CLEAR_I,
    input wire logic [NUM_SEQ-1:0] RESULT_QUEUE_POP_I,
    input wire logic CONV_DONE_I,
    input wire logic [RES_W-1:0] CONV_RESULT_I,
    output logic CONV_START_O,
    output logic [NIB_W-1:0] CONV_INPUT_O,
    output logic CONV_DIFF_O,
    output logic CONV_TEMP_O,
    output logic [NUM_SEQ-1:0][WORD_W-1:0] RESULT_QUEUE_PORT_O,
    output logic [NUM_SEQ-1:0] RESULT_QUEUE_VALID_O,
    output logic [NUM_SEQ-1:0][QSTATE_W-1:0] RESULT_QUEUE_STATE_O,
    output logic [NUM_SEQ-1:0] QUEUE_OVERRUN_STATE_O,
    output logic [NUM_SEQ-1:0] QUEUE_STARVE_STATE_O,
    output logic [NUM_SEQ-1:0] RAW_IRQ_STATE_O,
    output logic [NUM_SEQ-1:0] GATED_IRQ_STATE_O,
    output logic IRQ_O
);
    typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_START, ST_WAIT, ST_PUSH} adcss_eng_t;

    typedef struct packed {
        adcss_eng_t eng;
        logic [CNV_CNT_W-1:0] cnv_cnt;
        logic [NUM_SEQ-1:0] pend;
        logic [1:0] cur;
        logic [PTR_W-1:0] step;
        logic [ACC_W-1:0] acc;
        logic [AVG_MAX_LOG:0] avg_n;
        logic [NUM_SEQ*NIB_W-1:0] rank;
        logic [AVG_W-1:0] avg_log;
        logic [NUM_SEQ-1:0][MAX_STEPS-1:0][RES_W-1:0] mem;
        logic [NUM_SEQ-1:0][PTR_W-1:0] head;
        logic [NUM_SEQ-1:0][PTR_W-1:0] tail;
        logic [NUM_SEQ-1:0][CNT_W-1:0] cnt;
        logic [NUM_SEQ-1:0] raw;
        logic [NUM_SEQ-1:0] ovr;
        logic [NUM_SEQ-1:0] und;
        logic [NUM_SEQ-1:0] gated;
        logic irq;
        logic [NUM_SEQ-1:0][WORD_W-1:0] rdata;
        logic [NUM_SEQ-1:0] rvalid;
        logic [NUM_SEQ-1:0][QSTATE_W-1:0] qstate;
        logic start;
        logic [NIB_W-1:0] conv_in;
        logic diff;
        logic temp;
    } adcss_state_t;

    adcss_state_t r;
    adcss_state_t n;
    adcss_stream_if #(.W(BUF_W)) bin ();
    adcss_stream_if #(.W(BUF_W)) bout ();

    logic tick;
    logic [NUM_SEQ-1:0] trig;
    logic [NIB_W-1:0] sel_nib;
    logic [NIB_W-1:0] ctl_nib;
    logic conv_done;
    logic [RES_W-1:0] sample;
    logic last_step;
    logic [1:0] dq;

    // lowest rank value among requesters wins; ties go to the lower index
    function automatic logic [1:0] pick(input logic [NUM_SEQ-1:0] req,
                                        input logic [NUM_SEQ*NIB_W-1:0] rank);
        logic [1:0] best;
        logic [RANK_W:0] best_rank;
        best = 2'h0;
        best_rank = 3'h4;
        for (int i = 0; i < NUM_SEQ; i++) begin
            if (req[i] && {1'b0, rank[i*NIB_W +: RANK_W]} < best_rank) begin
                best = 2'(i);
                best_rank = {1'b0, rank[i*NIB_W +: RANK_W]};
            end
        end
        return best;
    endfunction

    function automatic logic [PTR_W-1:0] wrap(input logic [PTR_W-1:0] ptr, input logic [NIB_W-1:0] depth);
        return ({1'b0, ptr} == depth - 4'h1) ? '0 : ptr + 3'h1;
    endfunction

    adcss_buf #(.W(BUF_W)) u_buf (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .in_s(bin.snk),
        .out_s(bout.src)
    );

    assign bin.valid = (r.eng == ST_PUSH);
    assign bin.data = {r.cur, RES_W'(r.acc >> r.avg_log)};
    // queue side stalls the buffer in any cycle in which software reads
    assign bout.ready = ~|RESULT_QUEUE_POP_I;
    assign dq = bout.data[BUF_W-1 -: 2];

    // trigger decode per sequencer
    always_comb begin
        for (int i = 0; i < NUM_SEQ; i++) begin
            trig[i] = (TRIGGER_SOURCE_SELECT_I[i] == TRIG_SOFT && SOFTWARE_KICK_BITS_I[i])
                   || (TRIGGER_SOURCE_SELECT_I[i] == TRIG_ALWAYS)
                   || (TRIGGER_SOURCE_SELECT_I[i] >= TRIG_EVT_FIRST
                       && TRIGGER_SOURCE_SELECT_I[i] < TRIG_EVT_FIRST + 4'(EVT_W)
                       && TRIGGER_EVENT_I[3'(TRIGGER_SOURCE_SELECT_I[i] - TRIG_EVT_FIRST)]);
        end
    end

    assign sel_nib = STEP_INPUT_SELECT_I[r.cur][r.step];
    assign ctl_nib = STEP_CONTROL_NIBBLES_I[r.cur][r.step];
    assign tick = (r.cnv_cnt == CNV_LAST);
    // loopback completes on the next converter tick with a step signature
    assign conv_done = LOOPBACK_TEST_SETTING_I ? tick : CONV_DONE_I;
    // core code passed unchanged in normal mode, step signature in loopback mode
    assign sample = LOOPBACK_TEST_SETTING_I ? {r.cur, r.step, sel_nib, ctl_nib[CTL_DIFF_BIT]} : CONV_RESULT_I;
    // last-step flag, or the final step the sequencer holds
    // the depth bound only keeps an unmarked sequence from running away
    assign last_step = ctl_nib[CTL_LAST_BIT] || ({1'b0, r.step} == SEQ_DEPTH[r.cur] - 4'h1);

    always_comb begin
        n = r;
        n.start = 1'b0;
        n.rvalid = '0;
        n.cnv_cnt = tick ? '0 : r.cnv_cnt + 2'h1;
        if (SEQUENCER_RANK_WR_I) begin
            n.rank = SEQUENCER_RANK_I;
        end
        // one averaging setting for all steps
        if (AVERAGING_SETTING_WR_I) begin
            n.avg_log = (AVERAGING_SETTING_I > 3'(AVG_MAX_LOG)) ? 3'(AVG_MAX_LOG) : AVERAGING_SETTING_I;
        end
        // write one clears, hardware set below still wins
        n.raw = r.raw & ~GATED_IRQ_STATE_CLEAR_I;
        n.ovr = r.ovr & ~QUEUE_OVERRUN_CLEAR_I;
        n.und = r.und & ~QUEUE_STARVE_CLEAR_I;
        case (r.eng)
            ST_IDLE: begin
                if (|(r.pend & SEQUENCER_ACTIVATION_I)) begin
                    n.eng = ST_ARB;
                end
            end
            ST_ARB: begin
                // equal ranks resolve toward the lower index
                n.cur = pick(r.pend & SEQUENCER_ACTIVATION_I, r.rank);
                n.step = '0;
                n.acc = '0;
                n.avg_n = '0;
                n.eng = (|(r.pend & SEQUENCER_ACTIVATION_I)) ? ST_START : ST_IDLE;
            end
            ST_START: begin
                // a cleared run bit abandons the sequence
                if (!SEQUENCER_ACTIVATION_I[r.cur]) begin
                    n.pend[r.cur] = 1'b0;
                    n.eng = ST_IDLE;
                end else if (tick) begin
                    // any input, repeated or not, is converted as given
                    // differential pair k drives inputs 2k and 2k+1
                    n.start = 1'b1;
                    n.diff = ctl_nib[CTL_DIFF_BIT];
                    n.temp = ctl_nib[CTL_TEMP_BIT];
                    n.conv_in = ctl_nib[CTL_DIFF_BIT] ? {1'b0, sel_nib[1:0], 1'b0} : sel_nib;
                    n.eng = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (conv_done) begin
                    n.acc = r.acc + ACC_W'(sample);
                    n.avg_n = r.avg_n + 7'h1;
                    n.eng = (n.avg_n == 7'(1 << r.avg_log)) ? ST_PUSH : ST_START;
                end
            end
            ST_PUSH: begin
                if (bin.ready) begin
                    if (ctl_nib[CTL_IRQ_BIT]) begin
                        n.raw[r.cur] = 1'b1;
                    end
                    n.acc = '0;
                    n.avg_n = '0;
                    if (last_step) begin
                        n.pend[r.cur] = 1'b0;
                        n.eng = ST_IDLE;
                    end else begin
                        n.step = r.step + 3'h1;
                        n.eng = ST_START;
                    end
                end
            end
            default: begin
                n.eng = ST_IDLE;
            end
        endcase
        // triggers only latch for enabled sequencers, after any clear
        n.pend = n.pend | (trig & SEQUENCER_ACTIVATION_I);
        // circular queue push from the buffer
        if (bout.valid && bout.ready) begin
            if (r.cnt[dq] == SEQ_DEPTH[dq]) begin
                n.ovr[dq] = 1'b1;
            end else begin
                n.mem[dq][r.tail[dq]] = bout.data[RES_W-1:0];
                n.tail[dq] = wrap(r.tail[dq], SEQ_DEPTH[dq]);
                n.cnt[dq] = r.cnt[dq] + 4'h1;
            end
        end
        for (int q = 0; q < NUM_SEQ; q++) begin
            if (RESULT_QUEUE_POP_I[q]) begin
                if (r.cnt[q] == '0) begin
                    // starve on read of an empty queue
                    n.und[q] = 1'b1;
                end else begin
                    // result in the low bits of a 32-bit word
                    n.rdata[q] = {{(WORD_W - RES_W){1'b0}}, r.mem[q][r.head[q]]};
                    n.rvalid[q] = 1'b1;
                    n.head[q] = wrap(r.head[q], SEQ_DEPTH[q]);
                    n.cnt[q] = r.cnt[q] - 4'h1;
                end
            end
            n.qstate[q] = {n.cnt[q] == SEQ_DEPTH[q], n.cnt[q] == '0, 1'b0, n.head[q], 1'b0, n.tail[q]};
        end
        n.gated = n.raw & IRQ_ALLOW_REG_I;
        // interrupt line from allowed sequencers only
        n.irq = |n.gated;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            r <= '0;
            r.eng <= ST_IDLE;
            r.rank <= RANK_RESET;
            r.avg_log <= AVG_RESET;
            r.qstate <= {NUM_SEQ{QSTATE_RESET}};
        end else begin
            r <= n;
        end
    end

    assign CONV_START_O = r.start;
    assign CONV_INPUT_O = r.conv_in;
    assign CONV_DIFF_O = r.diff;
    assign CONV_TEMP_O = r.temp;
    assign RESULT_QUEUE_PORT_O = r.rdata;
    assign RESULT_QUEUE_VALID_O = r.rvalid;
    assign RESULT_QUEUE_STATE_O = r.qstate;
    assign QUEUE_OVERRUN_STATE_O = r.ovr;
    assign QUEUE_STARVE_STATE_O = r.und;
    assign RAW_IRQ_STATE_O = r.raw;
    assign GATED_IRQ_STATE_O = r.gated;
    assign IRQ_O = r.irq;

    // checks
    logic outranked;
    always_comb begin
        outranked = 1'b0;
        for (int i = 0; i < NUM_SEQ; i++) begin
            if (r.pend[i] && SEQUENCER_ACTIVATION_I[i]
                && r.rank[i*NIB_W +: RANK_W] < r.rank[n.cur*NIB_W +: RANK_W]) begin
                outranked = 1'b1;
            end
        end
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence s_start;
        CONV_START_O;
    endsequence
    sequence s_gap;
        !CONV_START_O [*2];
    endsequence

    conv_pacing_a: assert property (s_start |=> s_gap)
        else $error("conversion starts closer than the converter clock");
    run_gate_a: assert property (CONV_START_O |-> $past(SEQUENCER_ACTIVATION_I[r.cur]))
        else $error("conversion started for a stopped sequencer");
    rank_order_a: assert property ((r.eng == ST_ARB) |-> !outranked)
        else $error("lower ranked sequencer chosen");
    irq_line_a: assert property (IRQ_O == |(RAW_IRQ_STATE_O & $past(IRQ_ALLOW_REG_I)))
        else $error("interrupt line disagrees with allowed status");
    gated_status_a: assert property (GATED_IRQ_STATE_O == (RAW_IRQ_STATE_O & $past(IRQ_ALLOW_REG_I)))
        else $error("gated status is not raw and allow");
    irq_clear_a: assert property ((GATED_IRQ_STATE_CLEAR_I[0] && !(r.eng == ST_PUSH && bin.ready
        && ctl_nib[CTL_IRQ_BIT] && r.cur == 2'h0)) |=> !RAW_IRQ_STATE_O[0])
        else $error("write one did not clear interrupt");
    step_irq_a: assert property ((r.eng == ST_PUSH && bin.ready && ctl_nib[CTL_IRQ_BIT]) |=> RAW_IRQ_STATE_O[$past(r.cur)])
        else $error("step interrupt flag did not raise status");
    overrun_hold_a: assert property ((QUEUE_OVERRUN_STATE_O[0] && !QUEUE_OVERRUN_CLEAR_I[0]) |=> QUEUE_OVERRUN_STATE_O[0])
        else $error("overrun status lost");
    starve_set_a: assert property ((RESULT_QUEUE_POP_I[0] && r.cnt[0] == '0) |=> QUEUE_STARVE_STATE_O[0])
        else $error("read of empty queue not recorded");
    word_upper_a: assert property (RESULT_QUEUE_VALID_O[0] |-> RESULT_QUEUE_PORT_O[0][WORD_W-1:RES_W] == '0)
        else $error("upper bits of queue word not zero");
endmodule
`default_nettype wire

// ===== verif/adcss_core_model.sv
`default_nettype none
module adcss_core_model
    import adcss_pkg::*;
(
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [NIB_W-1:0] input_i,
    input wire logic diff_i,
    input wire logic temp_i,
    input wire logic [7:0] lat_i,
    output logic done_o,
    output logic [RES_W-1:0] result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic [RES_W-1:0] held = 10'h000;
    always @(posedge clk_i) begin
        if (start_i === 1'b1 && lat_i != 8'h00) begin
            cnt = int'(lat_i);
            held = temp_i ? 10'h2aa : (diff_i ? 10'h1ff + 10'(input_i) : {input_i, 6'h15});
        end
    end
    // result line toggles away from the answer outside the done pulse
    always @(negedge clk_i) begin
        if (cnt > 0) begin
            cnt = cnt - 1;
            done_o = (cnt == 0);
        end else begin
            done_o = 1'b0;
        end
        result_o = done_o ? held : ~held;
    end
endmodule
`default_nettype wire

// ===== verif/test_adc_sample_sequencer_control.sv
`default_nettype none
module test_adc_sample_sequencer_control;
    import adcss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, rank_wr, avg_wr, lpbk, done, start, cdiff, ctemp, irq;
    logic [NUM_SEQ-1:0] act, kick, allow, gclr, oclr, sclr, pop, qv, ovr, stv, raw, gated;
    logic [NUM_SEQ-1:0][MAX_STEPS-1:0][NIB_W-1:0] sel, ctl;
    logic [NUM_SEQ-1:0][NIB_W-1:0] tsel, rank;
    logic [NUM_SEQ-1:0][WORD_W-1:0] port;
    logic [NUM_SEQ-1:0][QSTATE_W-1:0] qst;
    logic [AVG_W-1:0] avg;
    logic [EVT_W-1:0] evt;
    logic [RES_W-1:0] cres;
    logic [NIB_W-1:0] cin;
    logic [7:0] lat;
    logic [5:0] seen[$];
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    adcss_top uut (.REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst), .SEQUENCER_ACTIVATION_I(act),
        .STEP_INPUT_SELECT_I(sel), .STEP_CONTROL_NIBBLES_I(ctl), .TRIGGER_SOURCE_SELECT_I(tsel),
        .TRIGGER_EVENT_I(evt), .SOFTWARE_KICK_BITS_I(kick), .SEQUENCER_RANK_I(rank), .SEQUENCER_RANK_WR_I(rank_wr),
        .AVERAGING_SETTING_I(avg), .AVERAGING_SETTING_WR_I(avg_wr), .LOOPBACK_TEST_SETTING_I(lpbk),
        .IRQ_ALLOW_REG_I(allow), .GATED_IRQ_STATE_CLEAR_I(gclr), .QUEUE_OVERRUN_CLEAR_I(oclr),
        .QUEUE_STARVE_CLEAR_I(sclr), .RESULT_QUEUE_POP_I(pop), .CONV_DONE_I(done), .CONV_RESULT_I(cres),
        .CONV_START_O(start), .CONV_INPUT_O(cin), .CONV_DIFF_O(cdiff), .CONV_TEMP_O(ctemp),
        .RESULT_QUEUE_PORT_O(port), .RESULT_QUEUE_VALID_O(qv), .RESULT_QUEUE_STATE_O(qst),
        .QUEUE_OVERRUN_STATE_O(ovr), .QUEUE_STARVE_STATE_O(stv), .RAW_IRQ_STATE_O(raw),
        .GATED_IRQ_STATE_O(gated), .IRQ_O(irq));
    adcss_core_model core (.clk_i(ref_clk), .start_i(start), .input_i(cin), .diff_i(cdiff), .temp_i(ctemp),
        .lat_i(lat), .done_o(done), .result_o(cres));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (start === 1'b1) seen.push_back({ctemp, cdiff, cin});
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic do_reset();
        sys_rst = 1'b1;
        {act, kick, allow, gclr, oclr, sclr, pop} = '0;
        sel = '0;
        ctl = '0;
        tsel = '0;
        rank = 16'h3210;
        {rank_wr, avg_wr, lpbk} = 3'h0;
        avg = 3'h0;
        evt = 8'h00;
        lat = 8'h03;
        tick(3);
        sys_rst = 1'b0;
        seen.delete();
    endtask
    task automatic kick_seq(input logic [NUM_SEQ-1:0] m);
        kick = m;
        tick(1);
        kick = '0;
    endtask
    task automatic wait_starts(input int n);
        for (int i = 0; i < 3000 && seen.size() < n; i++) tick(1);
        tick(15);
    endtask
    function automatic logic [31:0] code(input logic [5:0] s);
        if (s[5]) return 32'h2aa;
        if (s[4]) return 32'h1ff + 32'(s[3:0]);
        return {22'h0, s[3:0], 6'h15};
    endfunction
    task automatic pop_check(input int q, input logic [31:0] exp);
        logic got;
        got = 1'b0;
        pop[q] = 1'b1;
        tick(1);
        pop[q] = 1'b0;
        for (int i = 0; i < 4 && !got; i++) begin
            if (qv[q] === 1'b1) got = 1'b1;
            else tick(1);
        end
        check("queue valid", 32'h1, {31'h0, got});
        check("queue word", exp, port[q]);
        tick(1);
    endtask
    task automatic t_seq0();
        sel[0] = {4'h7, 4'h7, 4'h7, 4'h2, 4'h6, 4'h1, 4'h3, 4'h3};
        ctl[0][1] = 4'h4;
        ctl[0][4] = 4'h2;
        act = 4'h1;
        kick_seq(4'h1);
        wait_starts(5);
        check("start count", 32'd5, 32'(seen.size()));
        for (int i = 0; i < 5; i++) check("step input", 32'(sel[0][i]), 32'(seen[i]));
        check("raw irq", 32'h1, 32'(raw));
        check("gated irq", 32'h0, {27'h0, gated, irq});
        check("queue level", 32'h5, 32'(qst[0][6:4] ^ qst[0][2:0]));
        gclr = 4'h2;
        tick(1);
        gclr = '0;
        allow = 4'h1;
        tick(2);
        check("gated irq", 32'h3, {27'h0, gated, irq});
        gclr = 4'h1;
        tick(1);
        gclr = '0;
        tick(2);
        check("cleared irq", 32'h0, {23'h0, raw, gated, irq});
        for (int i = 0; i < 5; i++) pop_check(0, code({2'h0, sel[0][i]}));
        check("queue empty", 32'h1, 32'(qst[0][QST_EMPTY_BIT]));
        pop[0] = 1'b1;
        tick(1);
        pop[0] = 1'b0;
        tick(2);
        check("starve", 32'h1, {30'h0, qv[0], stv[0]});
        sclr = 4'h1;
        tick(1);
        sclr = '0;
        tick(1);
        check("starve cleared", 32'h0, 32'(stv));
    endtask
    task automatic t_depth();
        sel[3][0] = 4'h4;
        ctl[3][0] = 4'h2;
        act = 4'h8;
        kick_seq(4'h8);
        wait_starts(1);
        check("queue full", 32'h1, 32'(qst[3][QST_FULL_BIT]));
        sel[3][0] = 4'h9;
        kick_seq(4'h8);
        wait_starts(2);
        check("overrun", 32'h8, 32'(ovr));
        pop_check(3, code(6'h04));
        oclr = 4'h8;
        tick(1);
        oclr = '0;
        tick(2);
        check("overrun cleared", 32'h0, 32'(ovr));
    endtask
    task automatic t_rank();
        sel[1][0] = 4'h1;
        sel[2][0] = 4'h2;
        ctl[1][0] = 4'h2;
        ctl[2][0] = 4'h2;
        act = 4'h6;
        kick_seq(4'h6);
        wait_starts(2);
        check("first served", 32'h1, 32'(seen[0]));
        rank = 16'h3012;
        rank_wr = 1'b1;
        tick(1);
        rank_wr = 1'b0;
        seen.delete();
        kick_seq(4'h6);
        wait_starts(2);
        check("first served", 32'h2, 32'(seen[0]));
    endtask
    task automatic t_diff();
        logic [2:0][5:0] e;
        e = {6'h25, 6'h16, 6'h10};
        sel[1][2:0] = {4'h5, 4'h3, 4'h0};
        ctl[1][2:0] = {4'ha, 4'h1, 4'h1};
        act = 4'h2;
        kick_seq(4'h2);
        wait_starts(3);
        for (int i = 0; i < 3; i++) check("step drive", 32'(e[i]), 32'(seen[i]));
        for (int i = 0; i < 3; i++) pop_check(1, code(e[i]));
    endtask
    task automatic t_avg();
        avg = 3'h2;
        avg_wr = 1'b1;
        tick(1);
        avg_wr = 1'b0;
        lat = 8'h07;
        sel[3][0] = 4'h6;
        ctl[3][0] = 4'h2;
        act = 4'h8;
        kick_seq(4'h8);
        wait_starts(4);
        check("averaged starts", 32'd4, 32'(seen.size()));
        pop_check(3, code(6'h06));
    endtask
    task automatic t_loop_evt();
        lpbk = 1'b1;
        lat = 8'h00;
        sel[3][0] = 4'h5;
        ctl[3][0] = 4'h2;
        tsel[3] = 4'h3;
        evt = 8'h04;
        tick(1);
        evt = 8'h00;
        tick(20);
        check("idle when off", 32'h0, 32'(seen.size()));
        act = 4'h8;
        evt = 8'h04;
        tick(1);
        evt = 8'h00;
        wait_starts(1);
        check("event start", 32'h1, 32'(seen.size()));
        pop_check(3, 32'h30a);
        tsel[3] = TRIG_ALWAYS;
        wait_starts(4);
        check("always runs", 32'h1, 32'(seen.size() >= 4));
        act = 4'h0;
    endtask
    initial begin
        do_reset();
        for (int q = 0; q < NUM_SEQ; q++) check("queue state", 32'(QSTATE_RESET), 32'(qst[q]));
        check("flags", 32'h0, {raw, gated, ovr, stv, 15'h0, irq});
        t_seq0();
        do_reset();
        t_depth();
        do_reset();
        t_rank();
        do_reset();
        t_diff();
        do_reset();
        t_avg();
        do_reset();
        t_loop_evt();
        report_and_stop();
    end
endmodule
`default_nettype wire
